/* File: rtl/tmsc_map.vh */
`ifndef TMSC_MAP_VH
`define TMSC_MAP_VH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define TMSC_ADDR_STATUS 7'h03
`define TMSC_ADDR_OPMODE 7'h07
`define TMSC_ADDR_RATE_HI 7'h6e
`define TMSC_ADDR_RATE_LO 7'h6f
`define TMSC_ADDR_RATE_CFG 7'h70
`define TMSC_ADDR_MODCTL 7'h71
`define TMSC_ADDR_FIFO 7'h7f

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define TMSC_RST_MODCTL 8'h23
`define TMSC_RST_OPMODE 8'h00
`define TMSC_RST_RATE_HI 8'h0a
`define TMSC_RST_RATE_LO 8'haa
`define TMSC_RST_RATE_CFG 8'h00

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define TMSC_MODCTL_TYPE_LSB 0
`define TMSC_MODCTL_DEVMSB_BIT 2
`define TMSC_MODCTL_INV_BIT 3
`define TMSC_MODCTL_SRC_LSB 4
`define TMSC_MODCTL_CLK_LSB 6
`define TMSC_OP_TUNE_BIT 1
`define TMSC_OP_RX_BIT 2
`define TMSC_OP_TX_BIT 3
`define TMSC_RATE_SCALE_BIT 5
`define TMSC_ST_ERR_BIT 0
`define TMSC_ST_VALID_BIT 1
`define TMSC_ST_SENT_BIT 2

// ----------------------------------------------------------------------
// Encodings
// ----------------------------------------------------------------------
`define TMSC_MOD_CARRIER 2'h0
`define TMSC_MOD_OOK 2'h1
`define TMSC_MOD_FSK 2'h2
`define TMSC_MOD_GFSK 2'h3
`define TMSC_SRC_GPIO 2'h0
`define TMSC_SRC_SDI 2'h1
`define TMSC_SRC_FIFO 2'h2
`define TMSC_SRC_PN9 2'h3
`define TMSC_CLK_NONE 2'h0
`define TMSC_CLK_GPIO 2'h1
`define TMSC_CLK_SDO 2'h2
`define TMSC_CLK_IRQ 2'h3

// ----------------------------------------------------------------------
// Timing and sizes
// ----------------------------------------------------------------------
`define TMSC_CLK_PERIOD_NS 100
`define TMSC_REF_PERIOD_NS 1000
`define TMSC_REF_DIV (`TMSC_REF_PERIOD_NS / `TMSC_CLK_PERIOD_NS)
`define TMSC_TXCLK_HIGH_NS 1000
`define TMSC_TXCLK_HIGH_CYC (`TMSC_TXCLK_HIGH_NS / `TMSC_CLK_PERIOD_NS)
`define TMSC_PN9_SEED 9'h1ff
`define TMSC_FIFO_DEPTH 64

`endif

/* File: rtl/tmsc_tx_mod_ctrl.v */
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "tmsc_map.vh"

// Behaviour
// (R1) Modulation type field picks carrier, OOK, FSK or GFSK.
// (R2) Host enables a data clock when GFSK uses a direct source.
// (R3) Data source field picks GPIO pin, serial-in pin, FIFO or PN9.
// (R4) Serial-in direct data accepted only while chip select is high.
// (R5) Host configures a general-purpose pin to match its chosen role.
// (R6) FIFO mode moves data through FIFOs behind one burst access register.
// (R7) FIFO mode leaves transmit or receive on packet sent or packet valid.
// (R8) After packet sent, transmit is cleared; tune bit keeps tune state.
// (R9) With only transmit set, completion returns to idle.
// (R10) Receive bit cleared only by packet valid.
// (R11) CRC, header or sync error flags status and stays in receive.
// (R12) Direct mode modulates each pin bit live, nothing stored.
// (R13) Host drives only data for FSK, data plus clock for GFSK.
// (R14) Clock source field routes data clock to none, GPIO, serial-out, IRQ.
// (R15) Data clock on serial-out pin only while chip select is high.
// (R16) Invert bit flips transmit data before modulation.
// (R17) PN9 source makes transmit bits internally.
// (R18) Clockless direct mode allowed only with FSK.
// (R19) Host should set the rate to maximum for clockless FSK.
// (R20) Bit rate is rate word times 1 MHz over two to 16 plus 5 times scale.
// (R21) One clock pulse per bit; host data stable before sampling edge.
// (R22) PN9 is a nine-stage maximal LFSR, running while PN9 transmit active.
module tmsc_tx_mod_ctrl (
    // Clock and reset
    input wire CLK_SYS_IN,
    input wire ARST_N_IN,
    // Register port
    input wire [6:0] REG_ADDR_IN,
    input wire [7:0] REG_WDATA_IN,
    input wire REG_WR_IN,
    input wire REG_RD_IN,
    output reg [7:0] REG_RDATA_OUT,
    // Pins
    input wire CHIP_SELECT_N_IN,
    input wire SDI_IN,
    input wire GPIO_DATA_IN,
    output wire SDO_OUT,
    output wire SDO_OE_OUT,
    output wire GPIO_CLK_OUT,
    output wire GPIO_CLK_OE_OUT,
    output wire INTERRUPT_REQUEST_N_OUT,
    // Packet handler
    input wire PKT_VALID_IN,
    input wire PKT_ERROR_IN,
    input wire [7:0] RX_BYTE_IN,
    input wire RX_BYTE_VALID_IN,
    // Modulator
    output wire [1:0] MOD_TYPE_OUT,
    output reg MOD_DATA_OUT,
    output wire DEVIATION_MSB_OUT,
    output wire [3:0] STATE_OUT
);

    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_TUNE = 4'b0010;
    localparam [3:0] ST_TX = 4'b0100;
    localparam [3:0] ST_RX = 4'b1000;
    localparam [31:0] REF_LAST = `TMSC_REF_DIV - 1;
    localparam [31:0] CLK_HIGH_LAST = `TMSC_TXCLK_HIGH_CYC - 1;

    // ------------------------------------------------------------------
    // Registers and configuration fields
    // ------------------------------------------------------------------
    reg [7:0] modctl;
    reg [7:0] opmode;
    reg [7:0] rate_hi;
    reg [7:0] rate_lo;
    reg [7:0] rate_cfg;
    reg [2:0] status;
    reg [3:0] state;
    reg [3:0] next_state;

    wire [1:0] mod_type = modctl[`TMSC_MODCTL_TYPE_LSB+1:`TMSC_MODCTL_TYPE_LSB];
    wire [1:0] data_src = modctl[`TMSC_MODCTL_SRC_LSB+1:`TMSC_MODCTL_SRC_LSB];
    wire [1:0] clk_src = modctl[`TMSC_MODCTL_CLK_LSB+1:`TMSC_MODCTL_CLK_LSB];
    wire invert = modctl[`TMSC_MODCTL_INV_BIT];
    wire rate_scale = rate_cfg[`TMSC_RATE_SCALE_BIT];
    wire [15:0] rate_word = {rate_hi, rate_lo};
    wire fifo_mode = (data_src == `TMSC_SRC_FIFO);
    wire pn9_mode = (data_src == `TMSC_SRC_PN9);
    wire direct_mode = ~data_src[1];
    wire tx_on = opmode[`TMSC_OP_TX_BIT];
    wire rx_on = opmode[`TMSC_OP_RX_BIT];

    wire wr_fifo = REG_WR_IN && (REG_ADDR_IN == `TMSC_ADDR_FIFO);
    wire rd_fifo = REG_RD_IN && (REG_ADDR_IN == `TMSC_ADDR_FIFO);
    wire rd_status = REG_RD_IN && (REG_ADDR_IN == `TMSC_ADDR_STATUS);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    reg [1:0] cs_sync;
    reg [1:0] sdi_sync;
    reg [1:0] gpio_sync;

    always @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            cs_sync <= 2'h3;
            sdi_sync <= 2'h0;
            gpio_sync <= 2'h0;
        end else begin
            cs_sync <= {cs_sync[0], CHIP_SELECT_N_IN};
            sdi_sync <= {sdi_sync[0], SDI_IN};
            gpio_sync <= {gpio_sync[0], GPIO_DATA_IN};
        end
    end

    wire cs_high = cs_sync[1];
    // Serial-in pin is a data source only while the bus is deselected
    wire sdi_bit = sdi_sync[1] & cs_high; // (R4)
    wire direct_bit = (data_src == `TMSC_SRC_SDI) ? sdi_bit : gpio_sync[1]; // (R3)

    // ------------------------------------------------------------------
    // Bit rate generator
    // ------------------------------------------------------------------
    reg [3:0] ref_cnt;
    reg [20:0] rate_acc;
    wire ref_tick = (ref_cnt == REF_LAST[3:0]);
    wire [21:0] rate_sum = {1'b0, rate_acc} + {6'h00, rate_word};
    wire bit_tick = ref_tick && (rate_scale ? rate_sum[21] : rate_sum[16]); // (R20)

    always @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            ref_cnt <= 4'h0;
            rate_acc <= 21'h0;
        end else begin
            ref_cnt <= ref_tick ? 4'h0 : ref_cnt + 4'h1;
            if (!tx_on)
                rate_acc <= 21'h0;
            else if (ref_tick)
                rate_acc <= rate_scale ? rate_sum[20:0] : {5'h00, rate_sum[15:0]}; // (R20)
        end
    end

    // ------------------------------------------------------------------
    // Transmit and receive FIFOs
    // ------------------------------------------------------------------
    reg [7:0] tx_mem [0:`TMSC_FIFO_DEPTH-1];
    reg [7:0] rx_mem [0:`TMSC_FIFO_DEPTH-1];
    reg [6:0] tx_wp;
    reg [6:0] tx_rp;
    reg [6:0] rx_wp;
    reg [6:0] rx_rp;
    wire tx_empty = (tx_wp == tx_rp);
    wire tx_full = (tx_wp == {~tx_rp[6], tx_rp[5:0]});
    wire rx_empty = (rx_wp == rx_rp);
    wire rx_full = (rx_wp == {~rx_rp[6], rx_rp[5:0]});

    reg [7:0] shifter;
    reg [3:0] bits_left;
    wire fifo_bit_step = tx_on && fifo_mode && bit_tick;
    wire tx_pop = fifo_bit_step && (bits_left == 4'h0) && !tx_empty;
    wire pkt_sent = fifo_bit_step && (bits_left == 4'h0) && tx_empty;
    wire rx_push = rx_on && RX_BYTE_VALID_IN && !rx_full;

    always @(posedge CLK_SYS_IN) begin
        if (wr_fifo && !tx_full)
            tx_mem[tx_wp[5:0]] <= REG_WDATA_IN; // (R6)
        if (rx_push)
            rx_mem[rx_wp[5:0]] <= RX_BYTE_IN; // (R6)
    end

    always @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            tx_wp <= 7'h00;
            tx_rp <= 7'h00;
            rx_wp <= 7'h00;
            rx_rp <= 7'h00;
            shifter <= 8'h00;
            bits_left <= 4'h0;
        end else begin
            if (wr_fifo && !tx_full)
                tx_wp <= tx_wp + 7'h01;
            if (rd_fifo && !rx_empty)
                rx_rp <= rx_rp + 7'h01;
            if (rx_push)
                rx_wp <= rx_wp + 7'h01;
            if (tx_pop) begin
                tx_rp <= tx_rp + 7'h01;
                shifter <= {tx_mem[tx_rp[5:0]][6:0], 1'b0};
                bits_left <= 4'h7;
            end else if (fifo_bit_step && bits_left != 4'h0) begin
                shifter <= {shifter[6:0], 1'b0};
                bits_left <= bits_left - 4'h1;
            end else if (!tx_on) begin
                bits_left <= 4'h0;
            end
        end
    end

    // ------------------------------------------------------------------
    // PN9 generator, x^9 + x^5 + 1
    // ------------------------------------------------------------------
    reg [8:0] pn9;

    always @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN)
            pn9 <= `TMSC_PN9_SEED;
        else if (tx_on && pn9_mode && bit_tick)
            pn9 <= {pn9[7:0], pn9[8] ^ pn9[4]}; // (R17) (R22)
    end

    // ------------------------------------------------------------------
    // Transmit data path and data clock
    // ------------------------------------------------------------------
    reg [3:0] clk_high_cnt;
    reg data_clk;
    reg next_bit;
    wire clocked = (clk_src != `TMSC_CLK_NONE);

    always @* begin
        next_bit = MOD_DATA_OUT ^ invert;
        case (data_src)
            `TMSC_SRC_FIFO: if (fifo_bit_step)
                next_bit = tx_pop ? tx_mem[tx_rp[5:0]][7] : shifter[7]; // (R6)
            `TMSC_SRC_PN9: if (bit_tick)
                next_bit = pn9[8]; // (R17)
            default: if (!clocked || bit_tick)
                next_bit = direct_bit; // (R12) (R21)
        endcase
    end

    always @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            MOD_DATA_OUT <= 1'b0;
            data_clk <= 1'b0;
            clk_high_cnt <= 4'h0;
        end else begin
            MOD_DATA_OUT <= tx_on ? (next_bit ^ invert) : 1'b0; // (R16)
            if (tx_on && direct_mode && clocked && bit_tick) begin
                data_clk <= 1'b1; // (R21)
                clk_high_cnt <= CLK_HIGH_LAST[3:0];
            end else if (clk_high_cnt != 4'h0) begin
                clk_high_cnt <= clk_high_cnt - 4'h1;
            end else begin
                data_clk <= 1'b0;
            end
        end
    end

    // Clockless direct mode with anything but FSK falls back to carrier
    wire bad_async = direct_mode && !clocked && (mod_type != `TMSC_MOD_FSK); // (R18) (R2)
    assign MOD_TYPE_OUT = bad_async ? `TMSC_MOD_CARRIER : mod_type; // (R1)
    assign DEVIATION_MSB_OUT = modctl[`TMSC_MODCTL_DEVMSB_BIT];

    wire clk_route = tx_on && direct_mode;
    assign GPIO_CLK_OE_OUT = clk_route && (clk_src == `TMSC_CLK_GPIO); // (R14)
    assign GPIO_CLK_OUT = GPIO_CLK_OE_OUT & data_clk;
    assign SDO_OE_OUT = clk_route && (clk_src == `TMSC_CLK_SDO) && cs_high; // (R14) (R15)
    assign SDO_OUT = SDO_OE_OUT & data_clk;
    wire irq_clk = clk_route && (clk_src == `TMSC_CLK_IRQ); // (R14)
    assign INTERRUPT_REQUEST_N_OUT = irq_clk ? data_clk : ~(|status); // (R11)

    // ------------------------------------------------------------------
    // Operating state
    // ------------------------------------------------------------------
    always @* begin
        case (1'b1)
            opmode[`TMSC_OP_TX_BIT]: next_state = ST_TX;
            opmode[`TMSC_OP_RX_BIT]: next_state = ST_RX;
            opmode[`TMSC_OP_TUNE_BIT]: next_state = ST_TUNE; // (R8)
            default: next_state = ST_IDLE; // (R9)
        endcase
    end

    always @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN)
            state <= ST_IDLE;
        else
            state <= next_state;
    end

    assign STATE_OUT = state;

    // ------------------------------------------------------------------
    // Register writes, status flags and read data
    // ------------------------------------------------------------------
    wire pkt_valid = rx_on && fifo_mode && PKT_VALID_IN;

    always @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            modctl <= `TMSC_RST_MODCTL;
            opmode <= `TMSC_RST_OPMODE;
            rate_hi <= `TMSC_RST_RATE_HI;
            rate_lo <= `TMSC_RST_RATE_LO;
            rate_cfg <= `TMSC_RST_RATE_CFG;
            status <= 3'h0;
        end else begin
            if (pkt_sent)
                opmode[`TMSC_OP_TX_BIT] <= 1'b0; // (R7) (R8) (R9)
            if (pkt_valid)
                opmode[`TMSC_OP_RX_BIT] <= 1'b0; // (R7) (R10)
            if (REG_WR_IN) begin
                case (REG_ADDR_IN)
                    `TMSC_ADDR_MODCTL: modctl <= REG_WDATA_IN;
                    `TMSC_ADDR_OPMODE: opmode <= REG_WDATA_IN;
                    `TMSC_ADDR_RATE_HI: rate_hi <= REG_WDATA_IN;
                    `TMSC_ADDR_RATE_LO: rate_lo <= REG_WDATA_IN;
                    `TMSC_ADDR_RATE_CFG: rate_cfg <= REG_WDATA_IN;
                    default: ;
                endcase
            end
            // Reading clears the flags; a new event in that cycle still sets
            status <= (rd_status ? 3'h0 : status)
                | {pkt_sent, pkt_valid, rx_on & PKT_ERROR_IN}; // (R11)
        end
    end

    always @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            REG_RDATA_OUT <= 8'h00;
        end else if (REG_RD_IN) begin
            case (REG_ADDR_IN)
                `TMSC_ADDR_STATUS: REG_RDATA_OUT <= {5'h00, status};
                `TMSC_ADDR_OPMODE: REG_RDATA_OUT <= opmode;
                `TMSC_ADDR_RATE_HI: REG_RDATA_OUT <= rate_hi;
                `TMSC_ADDR_RATE_LO: REG_RDATA_OUT <= rate_lo;
                `TMSC_ADDR_RATE_CFG: REG_RDATA_OUT <= rate_cfg;
                `TMSC_ADDR_MODCTL: REG_RDATA_OUT <= modctl;
                `TMSC_ADDR_FIFO: REG_RDATA_OUT <= rx_empty ? 8'h00 : rx_mem[rx_rp[5:0]]; // (R6)
                default: REG_RDATA_OUT <= 8'h00;
            endcase
        end else begin
            REG_RDATA_OUT <= 8'h00;
        end
    end

endmodule // tmsc_tx_mod_ctrl

`default_nettype wire

/* File: verification/tmsc_tx_mod_ctrl_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module tmsc_tx_mod_ctrl_monitor (
    // Clock and reset
    input wire logic CLK_SYS_IN,
    input wire logic ARST_N_IN,
    // Watched ports
    input wire logic CHIP_SELECT_N_IN,
    input wire logic REG_WR_IN,
    input wire logic PKT_VALID_IN,
    input wire logic PKT_ERROR_IN,
    input wire logic SDO_OUT,
    input wire logic SDO_OE_OUT,
    input wire logic GPIO_CLK_OUT,
    input wire logic GPIO_CLK_OE_OUT,
    input wire logic INTERRUPT_REQUEST_N_OUT,
    input wire logic MOD_DATA_OUT,
    input wire logic [3:0] STATE_OUT
);
    default clocking cb @(posedge CLK_SYS_IN);
    endclocking
    default disable iff (!ARST_N_IN);
    // ----
    // Data clock pulse shapes, state, interrupt and pin checks
    // ----
    // Consecutive high cycles of the GPIO and serial-out data clock pins
    logic [7:0] gpio_hi;
    logic [7:0] sdo_hi;
    always @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            gpio_hi <= 8'h00;
            sdo_hi <= 8'h00;
        end else begin
            gpio_hi <= GPIO_CLK_OUT ? gpio_hi + 8'h01 : 8'h00;
            sdo_hi <= SDO_OUT ? sdo_hi + 8'h01 : 8'h00;
        end
    end
    // A pulse ends while its pin is still driven
    sequence s_gpio_end;
        $fell(GPIO_CLK_OUT) && GPIO_CLK_OE_OUT;
    endsequence
    sequence s_sdo_end;
        $fell(SDO_OUT) && SDO_OE_OUT;
    endsequence
    a_state_one_hot: assert property ($onehot(STATE_OUT))
        else $error("state not one-hot");
    a_rx_holds: assert property (STATE_OUT == 4'h8 && !PKT_VALID_IN && !$past(PKT_VALID_IN)
        && !REG_WR_IN && !$past(REG_WR_IN) |=> STATE_OUT == 4'h8) else $error("rx left");
    a_valid_exit: assert property (STATE_OUT == 4'h8 && PKT_VALID_IN
        |-> ##[1:3] STATE_OUT != 4'h8) else $error("rx kept after valid");
    a_error_irq: assert property (PKT_ERROR_IN |-> ##[1:2] !INTERRUPT_REQUEST_N_OUT)
        else $error("no irq on error");
    a_sdo_cs_gate: assert property (!CHIP_SELECT_N_IN [*3] |-> !SDO_OE_OUT)
        else $error("serial-out driven while selected");
    a_gpio_clk_high: assert property (s_gpio_end |-> gpio_hi == 8'h0a)
        else $error("gpio clock high time");
    a_sdo_clk_high: assert property (s_sdo_end |-> sdo_hi == 8'h0a)
        else $error("serial-out clock high time");
    a_clk_one_pin: assert property (!(GPIO_CLK_OE_OUT && SDO_OE_OUT))
        else $error("data clock routed to two pins");
    a_idle_quiet: assert property (STATE_OUT == 4'h1 && $past(STATE_OUT) == 4'h1
        |-> !MOD_DATA_OUT) else $error("data while idle");
endmodule // tmsc_tx_mod_ctrl_monitor
bind tmsc_tx_mod_ctrl tmsc_tx_mod_ctrl_monitor tmsc_tx_mod_ctrl_monitor_inst (
    .CLK_SYS_IN(CLK_SYS_IN), .ARST_N_IN(ARST_N_IN), .CHIP_SELECT_N_IN(CHIP_SELECT_N_IN),
    .REG_WR_IN(REG_WR_IN), .PKT_VALID_IN(PKT_VALID_IN), .PKT_ERROR_IN(PKT_ERROR_IN),
    .SDO_OUT(SDO_OUT), .SDO_OE_OUT(SDO_OE_OUT), .GPIO_CLK_OUT(GPIO_CLK_OUT),
    .GPIO_CLK_OE_OUT(GPIO_CLK_OE_OUT), .INTERRUPT_REQUEST_N_OUT(INTERRUPT_REQUEST_N_OUT),
    .MOD_DATA_OUT(MOD_DATA_OUT), .STATE_OUT(STATE_OUT));
`default_nettype wire

/* File: verification/tmsc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module tmsc_host_model (
    // Clock
    input wire logic clk_in,
    // Data clock from the device
    input wire logic data_clk_in,
    // Direct data to the device
    output logic data_bit_out
);
    logic clk_seen = 1'b0;
    initial data_bit_out = 1'b0;
    // Next bit only once the sampling clock has fallen
    always @(posedge clk_in) begin
        clk_seen <= data_clk_in;
        if (clk_seen && !data_clk_in) begin
            data_bit_out <= 1'($urandom_range(1, 0));
        end
    end
endmodule // tmsc_host_model
`default_nettype wire

/* File: verification/tmsc_tx_mod_ctrl_test.sv */
`timescale 1ns/1ps
`default_nettype none
module tmsc_tx_mod_ctrl_test;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [6:0] addr = 7'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0, rd = 1'b0, cs_n = 1'b1, sdi = 1'b0, pv = 1'b0, pe = 1'b0;
    logic [1:0] sel = 2'h1;
    logic [7:0] v;
    logic [31:0] bits, exp;
    logic b;
    int fail_count = 0, checks_done = 0, cycles = 0, n;
    wire [7:0] rdata;
    wire [1:0] mod_type;
    wire [3:0] state;
    wire sdo, sdo_oe, gclk, gclk_oe, irq_n, mod_data, dev_msb, host_bit;
    wire sel_clk = (sel == 2'h1) ? gclk : (sel == 2'h2) ? sdo : irq_n;
    always #50 clk = ~clk;
    tmsc_tx_mod_ctrl tmsc_tx_mod_ctrl_inst (
        .CLK_SYS_IN(clk), .ARST_N_IN(arst_n), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
        .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .CHIP_SELECT_N_IN(cs_n),
        .SDI_IN(sdi), .GPIO_DATA_IN(host_bit), .SDO_OUT(sdo), .SDO_OE_OUT(sdo_oe),
        .GPIO_CLK_OUT(gclk), .GPIO_CLK_OE_OUT(gclk_oe), .INTERRUPT_REQUEST_N_OUT(irq_n),
        .PKT_VALID_IN(pv), .PKT_ERROR_IN(pe), .RX_BYTE_IN(8'h00), .RX_BYTE_VALID_IN(1'b0),
        .MOD_TYPE_OUT(mod_type), .MOD_DATA_OUT(mod_data), .DEVIATION_MSB_OUT(dev_msb),
        .STATE_OUT(state));
    tmsc_host_model tmsc_host_model_inst (.clk_in(clk), .data_clk_in(sel_clk),
        .data_bit_out(host_bit));
    // ----
    // Bus and check tasks
    // ----
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [6:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic pulse(input logic err);
        @(posedge clk);
        {pe, pv} <= {err, !err};
        @(posedge clk);
        {pe, pv} <= 2'b00;
        tick(3);
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] want);
        checks_done++;
        if (got !== want) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask
    // Samples k transmitted bits in mid-bit, starting at the first high bit
    task automatic grab(input int k);
        n = 0;
        bits = 32'h0;
        while (mod_data !== 1'b1 && n < 400) begin
            tick(1);
            n++;
        end
        tick(10);
        repeat (k) begin
            bits = {bits[30:0], mod_data};
            tick(20);
        end
    endtask
    // Cycles until the selected data clock next rises
    task automatic wait_rise;
        n = 0;
        do begin
            tick(1);
            n++;
        end while (sel_clk !== 1'b0 && n < 400);
        while (sel_clk !== 1'b1 && n < 400) begin
            tick(1);
            n++;
        end
    endtask
    function automatic logic [31:0] pn9(input int k);
        logic [8:0] s;
        s = 9'h1ff;
        pn9 = 32'h0;
        repeat (k) begin
            pn9 = {pn9[30:0], s[8]};
            s = {s[7:0], s[8] ^ s[4]};
        end
    endfunction
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            fail_count++;
            report_and_stop();
        end
    end
    // ----
    // Scenarios
    // ----
    initial begin
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        void'($urandom(32'h9440));
        rd_reg(7'h71);
        cmp(v, 8'h23);
        cmp({mod_type, state, dev_msb, irq_n}, {2'h3, 4'h1, 1'b0, 1'b1});
        rd_reg(7'h10);
        cmp(v, 8'h00);
        for (int t = 0; t < 4; t++) begin
            wr_reg(7'h71, 8'h20 | 8'(t));
            tick(1);
            cmp(mod_type, t);
        end
        wr_reg(7'h6e, 8'h80);
        wr_reg(7'h6f, 8'h00);
        for (int m = 0; m < 2; m++) begin
            exp = 32'($urandom_range(255, 128));
            wr_reg(7'h7f, exp[7:0]);
            wr_reg(7'h07, m ? 8'h0a : 8'h08);
            grab(8);
            cmp(bits, exp);
            tick(40);
            cmp(state, m ? 4'h2 : 4'h1);
            rd_reg(7'h07);
            cmp(v, m ? 8'h02 : 8'h00);
            cmp(irq_n, 1'b0);
            rd_reg(7'h03);
            cmp(v, 8'h04);
            wr_reg(7'h07, 8'h00);
        end
        wr_reg(7'h71, 8'h32);
        wr_reg(7'h07, 8'h08);
        grab(24);
        cmp(bits, pn9(24));
        wr_reg(7'h71, 8'h22);
        wr_reg(7'h07, 8'h04);
        pulse(1'b1);
        cmp({state, irq_n}, {4'h8, 1'b0});
        rd_reg(7'h03);
        cmp(v, 8'h01);
        pulse(1'b0);
        cmp(state, 4'h1);
        rd_reg(7'h03);
        cmp(v, 8'h02);
        for (int c = 1; c < 7; c++) begin
            sel = 2'((c + 1) / 2);
            b = c[0];
            wr_reg(7'h71, {sel, 2'h0, b, 3'h3});
            wr_reg(7'h07, 8'h08);
            wait_rise();
            repeat (5) begin
                cmp(mod_data, host_bit ^ b);
                wait_rise();
                cmp(n, 20);
            end
            cmp({gclk_oe, sdo_oe}, {sel == 2'h1, sel == 2'h2});
            tick(10);
            cs_n = 1'b0;
            tick(4);
            cmp(sdo_oe, 1'b0);
            cs_n = 1'b1;
            tick(12);
            wr_reg(7'h07, 8'h00);
        end
        wr_reg(7'h71, 8'h12);
        wr_reg(7'h07, 8'h08);
        repeat (8) begin
            @(posedge clk);
            sdi <= 1'($urandom_range(1, 0));
            tick(6);
            cmp(mod_data, sdi);
        end
        @(posedge clk);
        {cs_n, sdi} <= 2'b01;
        tick(6);
        cmp(mod_data, 1'b0);
        cs_n = 1'b1;
        wr_reg(7'h71, 8'h13);
        tick(1);
        cmp(mod_type, 2'h0);
        report_and_stop();
    end
endmodule // tmsc_tx_mod_ctrl_test
`default_nettype wire
